/* src/stats_engine_pkg.sv */
// Summary of operation
// - Focus and exposure sub-engines each start from their own enable bit.
// - Always continuous; frames follow the capture controller video port timing.
// - Clearing an enable mid-frame takes effect only at that frame's end.
// - Each sub-engine gives one completion interrupt and one DMA event per frame.
// - At start of frame a busy flag sets only if its enable is 1.
// - Busy clears and DMA event fires when locked settings may change.
// - Completion interrupt waits until all frame output reached memory.
// - Both interrupts merge to one output, both DMA events to another.
// - Busy flag returns to 0 when its sub-engine finishes a frame.
// - Shadowed registers read back last write; hardware uses it from next frame.
// - Only main control and two buffer start registers are shadowed.
// - Writes to locked registers while busy complete but change nothing.
// - Subsystem hardware reset returns every register to its reset value.
package stats_engine_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FOCUS_BUF = 8'h04;
  localparam logic [7:0] ADDR_EXPO_BUF = 8'h08;
  localparam logic [7:0] ADDR_WIN_START = 8'h0c;
  localparam logic [7:0] ADDR_WIN_SIZE = 8'h10;
  localparam logic [7:0] ADDR_BLACK_WIN = 8'h14;
  localparam logic [7:0] ADDR_SUBSAMPLE = 8'h18;
  localparam logic [7:0] ADDR_PAXEL_CFG = 8'h1c;
  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // Main control field positions
  // ---------------------------------------------------------------
  localparam int BIT_FOCUS_EN = 0;
  localparam int BIT_MEDIAN_EN = 1;
  localparam int BIT_EXPO_EN = 2;
  localparam int BIT_COMPAND_EN = 3;
  localparam int BIT_FOCUS_BUSY = 4;
  localparam int BIT_EXPO_BUSY = 5;
  localparam int MEDIAN_THRESHOLD_LSB = 8;
  localparam int MEDIAN_THRESHOLD_W = 8;
  localparam int SAT_LSB = 16;
  localparam int SAT_W = 10;

  // Buffer addresses keep 64-byte alignment: low bits read as zero
  localparam int BUF_ALIGN_BITS = 6;
  localparam logic [31:0] BUF_ADDR_MASK = 32'hffff_ffc0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  localparam int NUM_ENGINES = 2;
  localparam int ENG_FOCUS = 0;
  localparam int ENG_EXPO = 1;

  typedef enum logic {
    ENG_IDLE,
    ENG_RUN
  } eng_state_t;

  // Frame-active control fields handed to the datapath
  typedef struct packed {
    logic [SAT_W-1:0] saturation_limit;
    logic [MEDIAN_THRESHOLD_W-1:0] median_threshold;
    logic exposure_compand_enable;
    logic exposure_engine_enable;
    logic focus_median_enable;
    logic focus_engine_enable;
  } stats_ctrl_t;

  // Busy-locked geometry settings
  typedef struct packed {
    logic [31:0] exposure_window_start;
    logic [31:0] exposure_window_size;
    logic [31:0] exposure_black_window;
    logic [31:0] exposure_subsample_cfg;
    logic [31:0] focus_paxel_cfg;
  } stats_geom_t;

endpackage

/* src/stats_subengine_seq.sv */
module stats_subengine_seq (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_sof,
  input wire logic i_eof,
  input wire logic i_enable,
  input wire logic i_wr_done,
  output logic o_busy,
  output logic o_event,
  output logic o_irq
);

  stats_engine_pkg::eng_state_t state_q, state_d;
  logic pending_q, pending_d;
  logic finish;
  logic irq_d;

  // A running frame closes at the frame end edge
  assign finish = (state_q == stats_engine_pkg::ENG_RUN) && i_eof;
  assign irq_d = pending_q && i_wr_done;
  // New finish wins over the drain acknowledge of the previous frame
  assign pending_d = (pending_q && !i_wr_done) || finish;

  always_comb begin
    state_d = state_q;
    case (state_q)
      stats_engine_pkg::ENG_IDLE: begin
        if (i_sof && i_enable) begin
          state_d = stats_engine_pkg::ENG_RUN;
        end
      end
      stats_engine_pkg::ENG_RUN: begin
        if (i_eof) begin
          state_d = stats_engine_pkg::ENG_IDLE;
        end
      end
      default: state_d = stats_engine_pkg::ENG_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= stats_engine_pkg::ENG_IDLE;
      pending_q <= 1'b0;
      o_busy <= 1'b0;
      o_event <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      state_q <= state_d;
      pending_q <= pending_d;
      o_busy <= (state_d == stats_engine_pkg::ENG_RUN);
      o_event <= finish;
      o_irq <= irq_d;
    end
  end

endmodule

/* src/stats_engine_ctrl.sv */
module stats_engine_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // AXI4-Lite slave
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Capture controller video port frame signal (high during a frame)
  input wire logic i_vp_frame,
  // Output write-back completion from each sub-engine's memory path
  input wire logic i_focus_wr_done,
  input wire logic i_exposure_wr_done,
  // Settings in use for the current frame
  output stats_engine_pkg::stats_ctrl_t o_active_ctrl,
  output logic [31:0] o_focus_buffer_start,
  output logic [31:0] o_exposure_buffer_start,
  output stats_engine_pkg::stats_geom_t o_geom,
  output logic o_focus_busy_flag,
  output logic o_exposure_busy_flag,
  output logic o_irq,
  output logic o_dma_event
);

  // ---------------------------------------------------------------
  // Video port synchroniser and frame edges
  // ---------------------------------------------------------------
  logic vp_meta_q;
  logic vp_sync_q;
  logic vp_prev_q;
  logic sof;
  logic eof;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vp_meta_q <= 1'b0;
      vp_sync_q <= 1'b0;
      vp_prev_q <= 1'b0;
    end else begin
      // Only the second and third stages feed logic; the first may still be settling
      vp_meta_q <= i_vp_frame;
      vp_sync_q <= vp_meta_q;
      vp_prev_q <= vp_sync_q;
    end
  end

  assign sof = vp_sync_q && !vp_prev_q;
  assign eof = !vp_sync_q && vp_prev_q;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  stats_engine_pkg::stats_ctrl_t ctrl_q;
  logic [31:0] focus_buf_q;
  logic [31:0] expo_buf_q;
  stats_engine_pkg::stats_geom_t geom_q;

  logic [stats_engine_pkg::NUM_ENGINES-1:0] eng_busy;
  logic [stats_engine_pkg::NUM_ENGINES-1:0] eng_event;
  logic [stats_engine_pkg::NUM_ENGINES-1:0] eng_irq;
  logic [stats_engine_pkg::NUM_ENGINES-1:0] eng_enable;
  logic [stats_engine_pkg::NUM_ENGINES-1:0] eng_wr_done;
  logic any_busy;

  assign eng_enable[stats_engine_pkg::ENG_FOCUS] = ctrl_q.focus_engine_enable;
  assign eng_enable[stats_engine_pkg::ENG_EXPO] = ctrl_q.exposure_engine_enable;
  assign eng_wr_done[stats_engine_pkg::ENG_FOCUS] = i_focus_wr_done;
  assign eng_wr_done[stats_engine_pkg::ENG_EXPO] = i_exposure_wr_done;
  assign any_busy = |eng_busy;

  // ---------------------------------------------------------------
  // Per-engine frame sequencing
  // ---------------------------------------------------------------
  // Each engine keeps its own state; only the outputs are merged
  genvar g;
  generate
    for (g = 0; g < stats_engine_pkg::NUM_ENGINES; g = g + 1) begin : gen_eng
      stats_subengine_seq u_seq (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_sof(sof),
        .i_eof(eof),
        .i_enable(eng_enable[g]),
        .i_wr_done(eng_wr_done[g]),
        .o_busy(eng_busy[g]),
        .o_event(eng_event[g]),
        .o_irq(eng_irq[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic aw_held_q;
  logic [7:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic [31:0] wr_mask;
  logic wr_mapped;
  logic wr_locked_reg;
  logic wr_allowed;

  // A new write waits until the previous response has been taken
  assign wr_fire = aw_held_q && w_held_q && !o_s_axi_bvalid;
  assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // Unmapped writes answer SLVERR and change nothing
  assign wr_mapped = (aw_addr_q == stats_engine_pkg::ADDR_MAIN_CTRL)
    || (aw_addr_q == stats_engine_pkg::ADDR_FOCUS_BUF)
    || (aw_addr_q == stats_engine_pkg::ADDR_EXPO_BUF)
    || (aw_addr_q == stats_engine_pkg::ADDR_WIN_START)
    || (aw_addr_q == stats_engine_pkg::ADDR_WIN_SIZE)
    || (aw_addr_q == stats_engine_pkg::ADDR_BLACK_WIN)
    || (aw_addr_q == stats_engine_pkg::ADDR_SUBSAMPLE)
    || (aw_addr_q == stats_engine_pkg::ADDR_PAXEL_CFG);

  assign wr_locked_reg = wr_mapped
    && (aw_addr_q != stats_engine_pkg::ADDR_MAIN_CTRL)
    && (aw_addr_q != stats_engine_pkg::ADDR_FOCUS_BUF)
    && (aw_addr_q != stats_engine_pkg::ADDR_EXPO_BUF);

  assign wr_allowed = wr_fire && !(wr_locked_reg && any_busy);

  // Plain byte-lane merge into a 32-bit register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      // Readies are flops that mirror the free state of each slot
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      w_held_q <= 1'b0;
      w_data_q <= stats_engine_pkg::RESET_WORD;
      w_strb_q <= '0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= stats_engine_pkg::RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        o_s_axi_awready <= 1'b0;
        aw_addr_q <= i_s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
        o_s_axi_awready <= 1'b1;
      end
      if (i_s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        o_s_axi_wready <= 1'b0;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
        o_s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        o_s_axi_bvalid <= 1'b1;
        // Blocked writes still answer OKAY; only unmapped ones fail
        o_s_axi_bresp <= wr_mapped ? stats_engine_pkg::RESP_OKAY
                                   : stats_engine_pkg::RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;

  assign ctrl_word = {{(32 - stats_engine_pkg::SAT_LSB - stats_engine_pkg::SAT_W){1'b0}},
                      ctrl_q.saturation_limit,
                      {(stats_engine_pkg::SAT_LSB - stats_engine_pkg::MEDIAN_THRESHOLD_LSB
                        - stats_engine_pkg::MEDIAN_THRESHOLD_W){1'b0}},
                      ctrl_q.median_threshold,
                      {(stats_engine_pkg::MEDIAN_THRESHOLD_LSB - stats_engine_pkg::BIT_EXPO_BUSY - 1){1'b0}},
                      eng_busy[stats_engine_pkg::ENG_EXPO],
                      eng_busy[stats_engine_pkg::ENG_FOCUS],
                      ctrl_q.exposure_compand_enable,
                      ctrl_q.exposure_engine_enable,
                      ctrl_q.focus_median_enable,
                      ctrl_q.focus_engine_enable};
  // Busy bits read live; a write to them is merged but never stored
  assign ctrl_new = merge(ctrl_word, w_data_q, wr_mask);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= '0;
      focus_buf_q <= stats_engine_pkg::RESET_WORD;
      expo_buf_q <= stats_engine_pkg::RESET_WORD;
      geom_q <= '0;
    end else if (wr_allowed) begin
      case (aw_addr_q)
        stats_engine_pkg::ADDR_MAIN_CTRL: begin
          ctrl_q.focus_engine_enable <= ctrl_new[stats_engine_pkg::BIT_FOCUS_EN];
          ctrl_q.focus_median_enable <= ctrl_new[stats_engine_pkg::BIT_MEDIAN_EN];
          ctrl_q.exposure_engine_enable <= ctrl_new[stats_engine_pkg::BIT_EXPO_EN];
          ctrl_q.exposure_compand_enable <= ctrl_new[stats_engine_pkg::BIT_COMPAND_EN];
          ctrl_q.median_threshold <=
            ctrl_new[stats_engine_pkg::MEDIAN_THRESHOLD_LSB +: stats_engine_pkg::MEDIAN_THRESHOLD_W];
          ctrl_q.saturation_limit <=
            ctrl_new[stats_engine_pkg::SAT_LSB +: stats_engine_pkg::SAT_W];
        end
        stats_engine_pkg::ADDR_FOCUS_BUF: begin
          focus_buf_q <= merge(focus_buf_q, w_data_q, wr_mask)
                         & stats_engine_pkg::BUF_ADDR_MASK;
        end
        stats_engine_pkg::ADDR_EXPO_BUF: begin
          expo_buf_q <= merge(expo_buf_q, w_data_q, wr_mask)
                        & stats_engine_pkg::BUF_ADDR_MASK;
        end
        stats_engine_pkg::ADDR_WIN_START: begin
          geom_q.exposure_window_start <= merge(geom_q.exposure_window_start, w_data_q, wr_mask);
        end
        stats_engine_pkg::ADDR_WIN_SIZE: begin
          geom_q.exposure_window_size <= merge(geom_q.exposure_window_size, w_data_q, wr_mask);
        end
        stats_engine_pkg::ADDR_BLACK_WIN: begin
          geom_q.exposure_black_window <= merge(geom_q.exposure_black_window, w_data_q, wr_mask);
        end
        stats_engine_pkg::ADDR_SUBSAMPLE: begin
          geom_q.exposure_subsample_cfg <=
            merge(geom_q.exposure_subsample_cfg, w_data_q, wr_mask);
        end
        stats_engine_pkg::ADDR_PAXEL_CFG: begin
          geom_q.focus_paxel_cfg <= merge(geom_q.focus_paxel_cfg, w_data_q, wr_mask);
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Shadow transfer at start of frame
  // ---------------------------------------------------------------
  // A write in the frame-start cycle lands one frame later
  // new values from next frame
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_active_ctrl <= '0;
      o_focus_buffer_start <= stats_engine_pkg::RESET_WORD;
      o_exposure_buffer_start <= stats_engine_pkg::RESET_WORD;
    end else if (sof) begin
      o_active_ctrl <= ctrl_q;
      o_focus_buffer_start <= focus_buf_q;
      o_exposure_buffer_start <= expo_buf_q;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic [31:0] rd_word;
  logic rd_mapped;
  logic rd_take;

  // Address is taken only while no read data waits for the master
  assign rd_take = i_s_axi_arvalid && !o_s_axi_rvalid;

  always_comb begin
    rd_word = stats_engine_pkg::RESET_WORD;
    rd_mapped = 1'b1;
    case (i_s_axi_araddr)
      stats_engine_pkg::ADDR_MAIN_CTRL: rd_word = ctrl_word;
      stats_engine_pkg::ADDR_FOCUS_BUF: rd_word = focus_buf_q;
      stats_engine_pkg::ADDR_EXPO_BUF: rd_word = expo_buf_q;
      stats_engine_pkg::ADDR_WIN_START: rd_word = geom_q.exposure_window_start;
      stats_engine_pkg::ADDR_WIN_SIZE: rd_word = geom_q.exposure_window_size;
      stats_engine_pkg::ADDR_BLACK_WIN: rd_word = geom_q.exposure_black_window;
      stats_engine_pkg::ADDR_SUBSAMPLE: rd_word = geom_q.exposure_subsample_cfg;
      stats_engine_pkg::ADDR_PAXEL_CFG: rd_word = geom_q.focus_paxel_cfg;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_arready <= 1'b1;
      o_s_axi_rdata <= stats_engine_pkg::RESET_WORD;
      o_s_axi_rresp <= stats_engine_pkg::RESP_OKAY;
    end else if (rd_take) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_arready <= 1'b0;
      o_s_axi_rdata <= rd_word;
      o_s_axi_rresp <= rd_mapped ? stats_engine_pkg::RESP_OKAY
                                 : stats_engine_pkg::RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Merged outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_geom <= '0;
      o_focus_busy_flag <= 1'b0;
      o_exposure_busy_flag <= 1'b0;
      o_irq <= 1'b0;
      o_dma_event <= 1'b0;
    end else begin
      o_geom <= geom_q;
      o_focus_busy_flag <= eng_busy[stats_engine_pkg::ENG_FOCUS];
      o_exposure_busy_flag <= eng_busy[stats_engine_pkg::ENG_EXPO];
      // Both engines end on the same frame edge, so their events share a pulse
      // merged irq and event
      o_irq <= |eng_irq;
      o_dma_event <= |eng_event;
    end
  end

endmodule

/* verif/stats_engine_chk.sv */
module stats_engine_chk (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_vp_frame,
  input wire logic i_focus_wr_done,
  input wire logic i_exposure_wr_done,
  input wire stats_engine_pkg::stats_ctrl_t o_active_ctrl,
  input wire logic [31:0] o_focus_buffer_start,
  input wire logic [31:0] o_exposure_buffer_start,
  input wire stats_engine_pkg::stats_geom_t o_geom,
  input wire logic o_focus_busy_flag,
  input wire logic o_exposure_busy_flag,
  input wire logic o_irq,
  input wire logic o_dma_event
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire any_busy = o_focus_busy_flag | o_exposure_busy_flag;

  busy_focus_a:
    assert property ($rose(o_focus_busy_flag) |-> o_active_ctrl.focus_engine_enable)
    else $error("focus busy set while disabled");
  busy_expo_a:
    assert property ($rose(o_exposure_busy_flag) |-> o_active_ctrl.exposure_engine_enable)
    else $error("exposure busy set while disabled");
  busy_sof_a:
    assert property ($rose(any_busy) |-> $past(i_vp_frame, 3))
    else $error("busy set outside a frame");
  busy_eof_a:
    assert property ($fell(o_focus_busy_flag) || $fell(o_exposure_busy_flag)
      |-> !$past(i_vp_frame, 3)) else $error("busy cleared before frame end");
  dma_clear_a:
    assert property ($fell(o_focus_busy_flag) || $fell(o_exposure_busy_flag)
      |-> o_dma_event) else $error("busy clear without event");
  dma_cause_a:
    assert property (o_dma_event |-> $fell(o_focus_busy_flag) || $fell(o_exposure_busy_flag))
    else $error("event without busy clear");
  dma_pulse_a:
    assert property (o_dma_event |=> !o_dma_event) else $error("event longer than a cycle");
  irq_done_a:
    assert property (o_irq |-> $past(i_focus_wr_done, 2) || $past(i_exposure_wr_done, 2))
    else $error("interrupt before data drained");
  geom_lock_a:
    assert property ($past(any_busy) && $past(any_busy, 2) |-> $stable(o_geom))
    else $error("locked settings changed while busy");
  buf_align_a:
    assert property ((o_focus_buffer_start[5:0] | o_exposure_buffer_start[5:0]) == 6'h00)
    else $error("buffer start not aligned");
endmodule

bind stats_engine_ctrl stats_engine_chk u_stats_engine_chk (.i_ref_clk, .i_resetn,
  .i_vp_frame, .i_focus_wr_done, .i_exposure_wr_done, .o_active_ctrl, .o_focus_buffer_start,
  .o_exposure_buffer_start, .o_geom, .o_focus_busy_flag, .o_exposure_busy_flag, .o_irq,
  .o_dma_event);

/* verif/frame_source_model.sv */
module frame_source_model (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_frame_req,
  input wire logic [7:0] i_focus_lag,
  input wire logic [7:0] i_exposure_lag,
  output logic o_vp_frame,
  output logic o_focus_wr_done,
  output logic o_exposure_wr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int fcnt;
  int ecnt;
  // frame level and drain
  // A zero lag means that engine wrote nothing this frame
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_vp_frame <= 1'b0;
      o_focus_wr_done <= 1'b0;
      o_exposure_wr_done <= 1'b0;
      fcnt <= 0;
      ecnt <= 0;
    end else begin
      o_vp_frame <= i_frame_req;
      o_focus_wr_done <= (fcnt == 1);
      o_exposure_wr_done <= (ecnt == 1);
      if (o_vp_frame && !i_frame_req) begin
        fcnt <= i_focus_lag;
        ecnt <= i_exposure_lag;
      end else begin
        fcnt <= (fcnt > 0) ? fcnt - 1 : 0;
        ecnt <= (ecnt > 0) ? ecnt - 1 : 0;
      end
    end
  end
endmodule

/* verif/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_resetn, awv, wv, bready, arv, rready, freq, mbf, mbe;
  logic [7:0] awaddr, araddr, flag, elag;
  logic [31:0] wdata, seed, abuf;
  logic [3:0] wstrb;
  logic [31:0] mdl [8];
  wire logic awr, wr_rdy, bv, arr, rv, vp, fdone, edone, fbusy, ebusy, irq, dma;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, fbuf, ebuf;
  wire stats_engine_pkg::stats_ctrl_t actl;
  wire stats_engine_pkg::stats_geom_t geom;
  int failures, num_checks, nirq, ndma;

  stats_engine_ctrl u_stats_engine_ctrl (.i_ref_clk, .i_resetn, .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rready), .i_vp_frame(vp), .i_focus_wr_done(fdone),
    .i_exposure_wr_done(edone), .o_active_ctrl(actl), .o_focus_buffer_start(fbuf),
    .o_exposure_buffer_start(ebuf), .o_geom(geom), .o_focus_busy_flag(fbusy),
    .o_exposure_busy_flag(ebusy), .o_irq(irq), .o_dma_event(dma));
  frame_source_model u_frame_source_model (.i_ref_clk, .i_resetn, .i_frame_req(freq),
    .i_focus_lag(flag), .i_exposure_lag(elag), .o_vp_frame(vp),
    .o_focus_wr_done(fdone), .o_exposure_wr_done(edone));

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (irq === 1'b1) nirq++;
    if (dma === 1'b1) ndma++;
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    failures++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Bus and frame tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Model follows the map: only idle time lets locked places change
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    logic [31:0] m;
    @(posedge i_ref_clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge i_ref_clk);
      if (pa && awr) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr_rdy) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    do @(posedge i_ref_clk); while (bv !== 1'b1);
    bready <= 1'b0;
    chk(bresp, (a >= 8'h20) ? 2'b10 : 2'b00, "write response");
    // Byte lanes without a strobe keep their old model value
    m = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    d = (mdl[a[4:2]] & ~m) | (d & m);
    if (a == 8'h00) mdl[0] = d & 32'h03ff_ff0f;
    else if (a < 8'h0c) mdl[a[4:2]] = d & 32'hffff_ffc0;
    else if (a < 8'h20 && !(mbf || mbe)) mdl[a[4:2]] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    e = (a < 8'h20) ? mdl[a[4:2]] : 32'h0;
    if (a == 8'h00) e = e | {26'h0, mbe, mbf, 4'h0};
    @(posedge i_ref_clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge i_ref_clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge i_ref_clk); while (rv !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e, "read data");
    chk(rresp, (a >= 8'h20) ? 2'b10 : 2'b00, "read response");
  endtask
  task automatic fbegin();
    nirq = 0;
    ndma = 0;
    freq <= 1'b1;
    repeat (12) @(posedge i_ref_clk);
    mbf = mdl[0][0];
    mbe = mdl[0][2];
    abuf = mdl[1];
    flag <= mbf ? 8'd8 : 8'd0;
    elag <= mbe ? 8'd20 : 8'd0;
    chk(fbusy, mbf, "focus busy");
    chk(ebusy, mbe, "exposure busy");
    chk(fbuf, abuf, "focus buffer");
    chk(ebuf, mdl[2], "exposure buffer");
    chk(actl, {mdl[0][25:16], mdl[0][15:8], mdl[0][3:0]}, "active control");
    chk(geom.exposure_window_size, mdl[4], "window size");
    chk(geom.focus_paxel_cfg, mdl[7], "paxel config");
  endtask
  task automatic fend();
    chk(fbuf, abuf, "focus buffer held");
    freq <= 1'b0;
    repeat (40) @(posedge i_ref_clk);
    chk(fbusy, 1'b0, "focus busy clear");
    chk(ebusy, 1'b0, "exposure busy clear");
    chk(ndma, mbf | mbe, "event count");
    chk(nirq, mbf + mbe, "interrupt count");
    mbf = 1'b0;
    mbe = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    i_resetn = 1'b0;
    awv = 1'b0;
    wv = 1'b0;
    arv = 1'b0;
    bready = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    freq = 1'b0;
    flag = 8'h00;
    elag = 8'h00;
    seed = 32'hadd8;
    mbf = 1'b0;
    mbe = 1'b0;
    abuf = 32'h0;
    failures = 0;
    num_checks = 0;
    nirq = 0;
    ndma = 0;
    foreach (mdl[i]) mdl[i] = 32'h0;
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rd(a[7:0]);
    for (int a = 0; a <= 32; a += 4) begin
      seed = lfsr(seed);
      wstrb <= seed[7:4];
      wr(a[7:0], seed);
      rd(a[7:0]);
    end
    wstrb <= 4'hf;
    wr(8'h10, 32'h0010_0010);
    wr(8'h1c, 32'h0008_0006);
    wr(8'h04, 32'h0000_1000);
    wr(8'h00, 32'h0000_2003);
    fbegin();
    fend();
    wr(8'h00, 32'h0000_0005);
    fbegin();
    wr(8'h10, 32'h0022_0022);
    rd(8'h10);
    chk(geom.exposure_window_size, mdl[4], "window size locked");
    wr(8'h04, 32'h0000_2040);
    rd(8'h04);
    wr(8'h00, 32'h0);
    rd(8'h00);
    chk(fbusy, 1'b1, "focus busy held");
    fend();
    wr(8'h10, 32'h0022_0022);
    rd(8'h10);
    fbegin();
    fend();
    repeat (4) begin
      seed = lfsr(seed);
      wr(8'h00, seed);
      fbegin();
      fend();
    end
    conclude();
  end
endmodule
